//--- rtl/gpt_unit_regs.vh
// Constants for the general purpose timer unit
// Overview of operation
// - Five 16-bit timers: core A with aux A/B, core B with aux C.
// - Timers run alone or chain through a toggle latch into a longer base.
// - Module one timers select timer, gated, counter or encoder mode.
// - Timer mode counts prescaled clock; counter mode counts timer input pin edges.
// - Gated mode counts prescaled clock only while its input pin is high.
// - Module one timers step at most once per 16 clock phases.
// - Software sets direction; the direction pin may invert it when enabled.
// - Encoder mode derives steps and direction from phases on input and direction pins.
// - Core A toggle latch inverts on every wrap and may drive its output pin.
// - Core A latch transitions may clock aux timers A and B.
// - Aux A/B may be capture or reload registers and then do not count.
// - Capture aux copies core A on an edge of its own input pin.
// - Reload aux loads core A on pin edge or selected latch transition.
// - Aux A/B reloading on opposite latch edges give a free-running pulse train.
// - Module two timers step at most once per 8 phases, prescaled or external.
// - Core B latch inverts on every wrap; clocks aux C and/or drives output.
// - Core B wrap is exported for compare timers and may reload from capture register.
// - Capture pin edge copies aux C to capture register; optionally clears aux C.
// - Core A input or direction pin edges may also trigger the aux C capture.
`ifndef GPT_UNIT_REGS_VH
`define GPT_UNIT_REGS_VH

`define PHASE_PER_CYC 16'h0002
`define RES_ONE_PHASE 16'h0010
`define RES_TWO_PHASE 16'h0008
`define RES_ONE_CYC (`RES_ONE_PHASE / `PHASE_PER_CYC)
`define RES_TWO_CYC (`RES_TWO_PHASE / `PHASE_PER_CYC)

`define MODE_TIMER 2'b00
`define MODE_GATED 2'b01
`define MODE_COUNTER 2'b10
`define MODE_ENCODER 2'b11

`define AUX_COUNT 2'b00
`define AUX_CAPTURE 2'b01
`define AUX_RELOAD 2'b10

`define TMR_RST 16'h0000
`define TMR_MAX 16'hFFFF
`define FLAG_CAPTURE 5

`define PIN_CAPTURE 10
`define NUM_PINS 11

`endif

//--- rtl/gpt_unit.v
// General purpose timer unit: two timer modules and a capture/reload register
`timescale 1ns/1ns
`include "gpt_unit_regs.vh"

module gpt_unit (
	input wire clk_i,
	input wire rst_n_i,
	input wire [4:0] run_i,
	input wire [9:0] mode_i,
	input wire [14:0] prescale_sel_i,
	input wire [9:0] count_edge_i,
	input wire [4:0] dir_down_i,
	input wire [4:0] dir_pin_en_i,
	input wire [4:0] latch_clock_i,
	input wire [3:0] aux_mode_i,
	input wire [3:0] reload_latch_sel_i,
	input wire core_a_out_en_i,
	input wire core_b_out_en_i,
	input wire core_b_reload_en_i,
	input wire [1:0] capture_edge_i,
	input wire [1:0] capture_alt_i,
	input wire capture_clear_en_i,
	input wire [5:0] flag_clear_i,
	input wire aux_timer_a_input_pin_i,
	input wire aux_timer_a_direction_pin_i,
	input wire core_a_input_pin_i,
	input wire core_a_direction_pin_i,
	input wire aux_timer_b_input_pin_i,
	input wire aux_timer_b_direction_pin_i,
	input wire aux_timer_c_input_pin_i,
	input wire aux_timer_c_direction_pin_i,
	input wire core_b_input_pin_i,
	input wire core_b_direction_pin_i,
	input wire capture_input_pin_i,
	output wire [15:0] aux_timer_a_o,
	output wire [15:0] core_timer_a_o,
	output wire [15:0] aux_timer_b_o,
	output wire [15:0] aux_timer_c_o,
	output wire [15:0] core_timer_b_o,
	output wire [15:0] capture_reload_register_o,
	output wire core_a_toggle_output_o,
	output wire core_b_toggle_output_o,
	output wire core_b_wrap_o,
	output wire [5:0] flag_o
);

	// ==================================================================
	// Helpers
	function hit;
		input [15:0] cnt;
		input [15:0] base;
		input [2:0] sel;
		reg [15:0] mask;
		begin
			mask = (base << sel) - 16'h0001;
			hit = (cnt & mask) == mask;
		end
	endfunction

	function [16:0] step;
		input [15:0] v;
		input down;
		begin
			if (down) begin
				step = {v == `TMR_RST, v - 16'h0001};
			end else begin
				step = {v == `TMR_MAX, v + 16'h0001};
			end
		end
	endfunction

	function trig;
		input r;
		input f;
		input [1:0] sel;
		begin
			trig = (r & sel[0]) | (f & sel[1]);
		end
	endfunction

	// ==================================================================
	// Pin synchronisers
	wire [`NUM_PINS-1:0] pins = {capture_input_pin_i,
		core_b_direction_pin_i, core_b_input_pin_i,
		aux_timer_c_direction_pin_i, aux_timer_c_input_pin_i,
		aux_timer_b_direction_pin_i, aux_timer_b_input_pin_i,
		core_a_direction_pin_i, core_a_input_pin_i,
		aux_timer_a_direction_pin_i, aux_timer_a_input_pin_i};
	reg [`NUM_PINS-1:0] s1_q, s2_q, s3_q, f_q, fp_q;
	wire [`NUM_PINS-1:0] f_d = (~(s2_q ^ s3_q) & s3_q) | ((s2_q ^ s3_q) & f_q);
	wire [`NUM_PINS-1:0] rise = f_q & ~fp_q;
	wire [`NUM_PINS-1:0] fall = ~f_q & fp_q;
	wire [`NUM_PINS-1:0] chg = rise | fall;

	// ==================================================================
	// State
	reg [15:0] tmr_q [0:4];
	reg [15:0] tmr_d [0:4];
	reg [15:0] cnt_q, cr_q, cr_d;
	reg [4:0] pend_q, pend_d, pdn_q, pdn_d, wrap_d;
	reg tla_q, tla_p_q, tla_d, tlb_q, tlb_p_q, tlb_d;
	reg tao_q, tbo_q, wrapb_q, capt_d;
	reg [5:0] flag_q;
	reg ev, dn, busy, base_tick;
	reg [16:0] st;
	reg [1:0] amode;
	integer i;

	wire tla_rise = tla_q & ~tla_p_q;
	wire tla_fall = ~tla_q & tla_p_q;

	// ==================================================================
	// Next state
	always @* begin
		tla_d = tla_q;
		tlb_d = tlb_q;
		cr_d = cr_q;
		wrap_d = 5'h00;
		capt_d = 1'b0;
		pend_d = pend_q;
		pdn_d = pdn_q;
		ev = 1'b0;
		dn = 1'b0;
		busy = 1'b0;
		base_tick = 1'b0;
		st = 17'h0_0000;
		amode = `AUX_COUNT;
		for (i = 0; i < 5; i = i + 1) begin
			tmr_d[i] = tmr_q[i];
		end
		for (i = 0; i < 5; i = i + 1) begin
			// Module one steps every 8 cycles, module two every 4
			base_tick = hit(cnt_q, (i < 3) ? `RES_ONE_CYC : `RES_TWO_CYC, 3'd0);
			dn = dir_down_i[i] ^ (dir_pin_en_i[i] & f_q[2*i+1]);
			case (mode_i[2*i+:2])
				`MODE_TIMER: begin
					ev = hit(cnt_q, (i < 3) ? `RES_ONE_CYC : `RES_TWO_CYC,
						prescale_sel_i[3*i+:3]);
				end
				`MODE_GATED: begin
					ev = hit(cnt_q, (i < 3) ? `RES_ONE_CYC : `RES_TWO_CYC,
						prescale_sel_i[3*i+:3]) & f_q[2*i];
				end
				`MODE_COUNTER: begin
					if (latch_clock_i[i] && (i == 0 || i == 2)) begin
						ev = tla_q ^ tla_p_q;
					end else if (latch_clock_i[i] && i == 3) begin
						ev = tlb_q ^ tlb_p_q;
					end else begin
						ev = trig(rise[2*i], fall[2*i], count_edge_i[2*i+:2]);
					end
				end
				`MODE_ENCODER: begin
					// Simultaneous phase edges are ambiguous and dropped
					ev = chg[2*i] ^ chg[2*i+1];
					dn = chg[2*i] ? (f_q[2*i] == f_q[2*i+1]) : (f_q[2*i] != f_q[2*i+1]);
				end
				default: begin
					ev = 1'b0;
				end
			endcase
			busy = 1'b0;
			if (i == 0 || i == 2) begin
				busy = aux_mode_i[i+:2] != `AUX_COUNT;
			end
			// An event between base ticks is held until the tick; further events before it merge into one step
			if (ev & run_i[i] & ~busy) begin
				pend_d[i] = 1'b1;
				pdn_d[i] = dn;
			end
			// A stopped timer drops its held event so it cannot step later
			if (!run_i[i]) begin
				pend_d[i] = 1'b0;
			end
			if (base_tick & pend_d[i]) begin
				pend_d[i] = 1'b0;
				st = step(tmr_q[i], pdn_d[i]);
				tmr_d[i] = st[15:0];
				wrap_d[i] = st[16];
			end
		end
		if (wrap_d[1]) begin
			tla_d = ~tla_q;
		end
		if (wrap_d[4]) begin
			tlb_d = ~tlb_q;
			if (core_b_reload_en_i) begin
				tmr_d[4] = cr_q;
			end
		end
		// Aux B first so that aux A wins a simultaneous reload
		for (i = 2; i >= 0; i = i - 2) begin
			amode = aux_mode_i[i+:2];
			if (amode == `AUX_CAPTURE &&
				trig(rise[2*i], fall[2*i], count_edge_i[2*i+:2])) begin
				tmr_d[i] = tmr_q[1];
			end
			if (amode == `AUX_RELOAD &&
				(trig(rise[2*i], fall[2*i], count_edge_i[2*i+:2]) ||
				trig(tla_rise, tla_fall, reload_latch_sel_i[i+:2]))) begin
				tmr_d[1] = tmr_q[i];
			end
		end
		capt_d = trig(rise[`PIN_CAPTURE], fall[`PIN_CAPTURE], capture_edge_i) |
			(capture_alt_i[0] & chg[2]) | (capture_alt_i[1] & chg[3]);
		if (capt_d) begin
			cr_d = tmr_q[3];
			if (capture_clear_en_i) begin
				tmr_d[3] = `TMR_RST;
			end
		end
	end

	// ==================================================================
	// Registers
	always @(posedge clk_i) begin
		if (!rst_n_i) begin
			s1_q <= {`NUM_PINS{1'b0}};
			s2_q <= {`NUM_PINS{1'b0}};
			s3_q <= {`NUM_PINS{1'b0}};
			f_q <= {`NUM_PINS{1'b0}};
			fp_q <= {`NUM_PINS{1'b0}};
			for (i = 0; i < 5; i = i + 1) begin
				tmr_q[i] <= `TMR_RST;
			end
			cnt_q <= 16'h0000;
			cr_q <= `TMR_RST;
			pend_q <= 5'h00;
			pdn_q <= 5'h00;
			tla_q <= 1'b0;
			tla_p_q <= 1'b0;
			tlb_q <= 1'b0;
			tlb_p_q <= 1'b0;
			tao_q <= 1'b0;
			tbo_q <= 1'b0;
			wrapb_q <= 1'b0;
			flag_q <= 6'h00;
		end else begin
			s1_q <= pins;
			s2_q <= s1_q;
			s3_q <= s2_q;
			f_q <= f_d;
			fp_q <= f_q;
			for (i = 0; i < 5; i = i + 1) begin
				tmr_q[i] <= tmr_d[i];
			end
			cnt_q <= cnt_q + 16'h0001;
			cr_q <= cr_d;
			pend_q <= pend_d;
			pdn_q <= pdn_d;
			tla_q <= tla_d;
			tla_p_q <= tla_q;
			tlb_q <= tlb_d;
			tlb_p_q <= tlb_q;
			tao_q <= tla_d & core_a_out_en_i;
			tbo_q <= tlb_d & core_b_out_en_i;
			wrapb_q <= wrap_d[4];
			// A new event outranks a clear in the same cycle
			flag_q <= (flag_q & ~flag_clear_i) | {capt_d, wrap_d};
		end
	end

	assign aux_timer_a_o = tmr_q[0];
	assign core_timer_a_o = tmr_q[1];
	assign aux_timer_b_o = tmr_q[2];
	assign aux_timer_c_o = tmr_q[3];
	assign core_timer_b_o = tmr_q[4];
	assign capture_reload_register_o = cr_q;
	assign core_a_toggle_output_o = tao_q;
	assign core_b_toggle_output_o = tbo_q;
	assign core_b_wrap_o = wrapb_q;
	assign flag_o = flag_q;

endmodule // gpt_unit

//--- sim/gpt_unit_sva.sv
// Port assertions for the general purpose timer unit
`timescale 1ns/1ns
module gpt_unit_chk (
	input wire clk_i,
	input wire rst_n_i,
	input wire [4:0] run_i,
	input wire [3:0] aux_mode_i,
	input wire core_a_out_en_i,
	input wire core_b_out_en_i,
	input wire core_b_reload_en_i,
	input wire [15:0] core_timer_a_o,
	input wire [15:0] core_timer_b_o,
	input wire [15:0] capture_reload_register_o,
	input wire core_a_toggle_output_o,
	input wire core_b_toggle_output_o,
	input wire core_b_wrap_o,
	input wire [5:0] flag_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);
	// ==========================================
	// Sequences
	// Reload mode may move core a off the tick grid
	sequence a_step;
		$changed(core_timer_a_o) && !aux_mode_i[1] && !aux_mode_i[3];
	endsequence
	sequence b_halted;
		!run_i[4] ##1 !run_i[4];
	endsequence
	// ==========================================
	// Assertions
	a_core_a_res: assert property (a_step |=> $stable(core_timer_a_o)[*7])
		else $error("core a too fast");
	a_core_b_res: assert property (
		$changed(core_timer_b_o) |=> $stable(core_timer_b_o)[*3]) else $error("core b too fast");
	a_b_halt_hold: assert property (b_halted |-> $stable(core_timer_b_o))
		else $error("core b moved");
	a_b_wrap_value: assert property (core_b_wrap_o && !core_b_reload_en_i |->
		core_timer_b_o == 16'h0000 || core_timer_b_o == 16'hFFFF) else $error("wrap value");
	a_b_wrap_flag: assert property (core_b_wrap_o |-> ##[0:1] flag_o[4])
		else $error("wrap not flagged");
	a_b_toggle_flip: assert property (core_b_wrap_o && core_b_out_en_i &&
		$past(core_b_out_en_i) |-> core_b_toggle_output_o != $past(core_b_toggle_output_o))
		else $error("core b toggle");
	a_a_toggle_off: assert property (!core_a_out_en_i && !$past(core_a_out_en_i)
		|-> !core_a_toggle_output_o) else $error("core a toggle");
	a_capture_flag: assert property ($changed(capture_reload_register_o) |-> flag_o[5])
		else $error("capture flag");
endmodule // gpt_unit_chk
bind gpt_unit gpt_unit_chk chk_u (.*);

//--- sim/enc_model.sv
// Quadrature encoder model driving the core a phase pins
`timescale 1ns/1ns
module enc_model (
	input wire clk_i,
	input wire step_i,
	input wire rev_i,
	output wire phase_a_o,
	output wire phase_b_o
);
	logic [1:0] pos_q = 2'h0;
	// Gray steps: exactly one phase edge per request
	always @(posedge clk_i) begin
		if (step_i) pos_q <= rev_i ? pos_q - 2'h1 : pos_q + 2'h1;
	end
	assign phase_a_o = pos_q[1] ^ pos_q[0];
	assign phase_b_o = pos_q[1];
endmodule // enc_model

//--- sim/gpt_unit_bench.sv
// Self-checking bench for the general purpose timer unit
`timescale 1ns/1ns
module gpt_unit_bench;
	typedef struct {int k; int sel; bit dn; bit dp; int n; logic [15:0] v; bit f;} row_t;
	// Timer, prescale, down, direction pin, ticks, value, wrap flag
	row_t rows [5] = '{'{1, 0, 0, 0, 5, 16'h0005, 0}, '{1, 1, 1, 0, 2, 16'hFFFE, 1},
		'{2, 0, 0, 0, 4, 16'h0004, 0}, '{4, 0, 1, 0, 1, 16'hFFFF, 1},
		'{3, 2, 0, 1, 2, 16'hFFFE, 1}};
	logic clk_i = 0, rst_n_i = 0, enc_step = 0, enc_rev = 0;
	logic [4:0] run_i, dir_down_i, dir_pin_en_i, latch_clock_i;
	logic [9:0] mode_i, count_edge_i;
	logic [14:0] prescale_sel_i;
	logic [3:0] aux_mode_i, reload_latch_sel_i;
	logic [1:0] capture_edge_i, capture_alt_i;
	logic [5:0] flag_clear_i;
	logic core_a_out_en_i, core_b_out_en_i, core_b_reload_en_i, capture_clear_en_i;
	logic aux_timer_a_input_pin_i, aux_timer_a_direction_pin_i, aux_timer_b_input_pin_i;
	logic aux_timer_b_direction_pin_i, aux_timer_c_input_pin_i, aux_timer_c_direction_pin_i;
	logic core_b_input_pin_i, core_b_direction_pin_i, capture_input_pin_i;
	wire core_a_input_pin_i, core_a_direction_pin_i, core_a_toggle_output_o;
	wire core_b_toggle_output_o, core_b_wrap_o;
	wire [5:0] flag_o;
	wire [15:0] aux_timer_a_o, core_timer_a_o, aux_timer_b_o, aux_timer_c_o, core_timer_b_o;
	wire [15:0] capture_reload_register_o;
	int err_count = 0, compares = 0;
	function automatic logic [15:0] tv(input int k);
		case (k)
			0: return aux_timer_a_o;
			1: return core_timer_a_o;
			2: return aux_timer_b_o;
			3: return aux_timer_c_o;
			default: return core_timer_b_o;
		endcase
	endfunction
	gpt_unit dut_u (.*);
	enc_model enc_u (.clk_i(clk_i), .step_i(enc_step), .rev_i(enc_rev),
		.phase_a_o(core_a_input_pin_i), .phase_b_o(core_a_direction_pin_i));
	always #50 clk_i = ~clk_i;
	// ==========================================
	// Tasks
	task chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
		compares++;
		if (got !== exp) begin
			err_count++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task complete_run;
		if (err_count == 0 && compares > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	task cyc(input int n);
		repeat (n) @(negedge clk_i);
	endtask
	// Leaves reset asserted so the caller configures before release
	task do_reset;
		rst_n_i = 0;
		{run_i, dir_down_i, dir_pin_en_i, latch_clock_i, mode_i, count_edge_i, prescale_sel_i,
			aux_mode_i, reload_latch_sel_i, capture_edge_i, capture_alt_i, flag_clear_i,
			core_a_out_en_i, core_b_out_en_i, core_b_reload_en_i, capture_clear_en_i,
			aux_timer_a_input_pin_i, aux_timer_a_direction_pin_i, aux_timer_b_input_pin_i,
			aux_timer_b_direction_pin_i, aux_timer_c_input_pin_i, aux_timer_c_direction_pin_i,
			core_b_input_pin_i, core_b_direction_pin_i, capture_input_pin_i} = '0;
		cyc(5);
	endtask
	task wait_wrap;
		for (int i = 0; i < 40 && core_b_wrap_o !== 1'b1; i++) cyc(1);
		chk("wrap", 16'(core_b_wrap_o), 16'h0001);
	endtask
	// ==========================================
	// Sequence
	initial begin
		row_t r;
		int p;
		do_reset;
		foreach (rows[i]) begin
			r = rows[i];
			run_i[r.k] = 1;
			prescale_sel_i[3*r.k+:3] = r.sel[2:0];
			dir_down_i[r.k] = r.dn;
			dir_pin_en_i[r.k] = r.dp;
			core_a_out_en_i = 1;
			{aux_timer_a_direction_pin_i, aux_timer_b_direction_pin_i} = {2{r.dp}};
			{aux_timer_c_direction_pin_i, core_b_direction_pin_i} = {2{r.dp}};
			rst_n_i = 1;
			// Check mid-period so pin and tick latency cannot shift the count
			p = (r.k > 2 ? 4 : 8) << r.sel;
			cyc(r.n * p + p / 2);
			chk("value", tv(r.k), r.v);
			chk("flag", 16'(flag_o[r.k]), 16'(r.f));
			chk("toggle a", 16'(core_a_toggle_output_o), 16'((r.k == 1) && r.f));
			do_reset;
		end
		mode_i[5:4] = 2'b01;
		run_i[2] = 1;
		rst_n_i = 1;
		cyc(24);
		aux_timer_b_input_pin_i = 1;
		cyc(32);
		aux_timer_b_input_pin_i = 0;
		cyc(30);
		chk("gated", aux_timer_b_o, 16'h0004);
		do_reset;
		mode_i = 10'h20C;
		count_edge_i[9:8] = 2'b01;
		capture_alt_i = 2'b01;
		run_i = 5'b10010;
		rst_n_i = 1;
		for (int i = 0; i < 7; i++) begin
			enc_step = 1;
			enc_rev = (i >= 5);
			core_b_input_pin_i = ~core_b_input_pin_i;
			cyc(1);
			enc_step = 0;
			cyc(23);
		end
		chk("encoder", core_timer_a_o, 16'h0003);
		chk("events", core_timer_b_o, 16'h0004);
		chk("alt capture", 16'(flag_o[5]), 16'h0001);
		do_reset;
		aux_mode_i = 4'h1;
		count_edge_i[1:0] = 2'b01;
		capture_edge_i = 2'b01;
		capture_clear_en_i = 1;
		prescale_sel_i[5:3] = 3'h1;
		prescale_sel_i[11:9] = 3'h2;
		run_i = 5'b01011;
		rst_n_i = 1;
		cyc(52);
		{aux_timer_a_input_pin_i, capture_input_pin_i} = 2'b11;
		cyc(8);
		chk("aux capture", aux_timer_a_o, 16'h0003);
		chk("capture_reload_register", capture_reload_register_o, 16'h0003);
		chk("clear c", aux_timer_c_o, 16'h0000);
		cyc(40);
		chk("aux hold", aux_timer_a_o, 16'h0003);
		{core_b_reload_en_i, core_b_out_en_i, dir_down_i[4], run_i[4]} = 4'hF;
		wait_wrap;
		chk("reload", core_timer_b_o, 16'h0003);
		chk("toggle", 16'(core_b_toggle_output_o), 16'h0001);
		cyc(1);
		wait_wrap;
		chk("toggle back", 16'(core_b_toggle_output_o), 16'h0000);
		run_i = 0;
		do_reset;
		chk("reset flags", 16'(flag_o), 16'h0000);
		chk("reset capture_reload_register", capture_reload_register_o, 16'h0000);
		chk("reset core b", core_timer_b_o, 16'h0000);
		complete_run;
	end
	// Whole sequence needs about 600 cycles
	initial begin
		repeat (5000) @(posedge clk_i);
		err_count++;
		complete_run;
	end
endmodule // gpt_unit_bench
